/* pkg/pulse_count_pkg.sv */
// Purpose: Shared constants and types for the pulse counter and compare core
// Assumes: 50 MHz system clock, register port with one-cycle read latency
// Notes: Register offsets are word indices on the plain register port
package pulse_count_pkg;
   // Register offsets
   localparam logic [4:0] OFS_MODE = 5'h00;
   localparam logic [4:0] OFS_DIR = 5'h01;
   localparam logic [4:0] OFS_RING = 5'h02;
   localparam logic [4:0] OFS_COMMAND = 5'h04;
   localparam logic [4:0] OFS_HW_CMP = 5'h0C;
   localparam logic [4:0] OFS_SW_CMP = 5'h0E;
   localparam logic [4:0] OFS_COUNT = 5'h14;
   localparam logic [4:0] OFS_RESULTS = 5'h1A;
   localparam logic [4:0] OFS_PINS = 5'h1B;
   localparam logic [4:0] OFS_IRQ_STATUS = 5'h1C;
   localparam logic [4:0] OFS_IRQ_MASK = 5'h1D;
   // Command word bit positions
   localparam int CMD_CLR_HW = 0;
   localparam int CMD_CLR_SW = 1;
   // Interrupt bit positions
   localparam int IRQ_HW = 0;
   localparam int IRQ_SW = 1;
   localparam int IRQ_WRAP = 2;
   // Reset values and the smallest ring length
   localparam logic [3:0] MODE_RESET = 4'h0;
   localparam logic [16:0] RING_RESET = 17'h1_0000;
   localparam logic [16:0] RING_MIN = 17'h0_0002;
   localparam logic [31:0] CMP_RESET = 32'h0000_7FFF;
   // Software compare latency
   localparam int SYS_CLK_HZ = 50_000_000;
   localparam int SW_LATENCY_US = 300;
   localparam int SW_LATENCY_CYC = SW_LATENCY_US * (SYS_CLK_HZ / 1_000_000);
   localparam int SW_SCAN_DIV = 256;
   // Input style, decoded from the mode word
   typedef enum logic [2:0] {
      STYLE_EDGE1 = 3'b000,
      STYLE_EDGE2 = 3'b001,
      STYLE_EDGE4 = 3'b010,
      STYLE_ADDSUB = 3'b011,
      STYLE_HWDIR = 3'b100,
      STYLE_SWDIR = 3'b101
   } input_style_e;
   // Count request carried from the edge stage
   typedef struct packed {
      logic up;
      logic down;
   } count_step_s;
endpackage : pulse_count_pkg

/* src/phase_edge_detect.sv */
// Purpose: Synchronise the two phase inputs and report their edges
// Assumes: Raw pins are asynchronous to sys_clk
// Notes: First stage flops feed only the second stage
`timescale 1ns/10ps
`default_nettype none
module phase_edge_detect (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [1:0] phase_raw,
   output logic [1:0] phase_level,
   output logic [1:0] phase_rise,
   output logic [1:0] phase_fall
);
   logic [1:0] meta_reg;
   logic [1:0] sync_reg;
   logic [1:0] prev_reg;
   logic [1:0] meta_next;
   logic [1:0] sync_next;
   logic [1:0] prev_next;

   // Next values of the three-stage pipeline
   always_comb begin
      meta_next = phase_raw;
      sync_next = meta_reg;
      prev_next = sync_reg;
   end

   // Synchroniser and history register
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         meta_reg <= 2'h0;
         sync_reg <= 2'h0;
         prev_reg <= 2'h0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
         prev_reg <= prev_next;
      end
   end

   // Edges from the settled stages only
   assign phase_level = sync_reg;
   assign phase_rise = sync_reg & ~prev_reg;
   assign phase_fall = ~sync_reg & prev_reg;
endmodule : phase_edge_detect
`default_nettype wire

/* src/quadrature_pulse_counter_compare.sv */
// Purpose: Pulse counter with hardware and software compare outputs
// Assumes: Register port with one-cycle read data; phase pins asynchronous
// Notes: Software compare scans on a slow enable to model its bounded delay
// Behaviour
// - Except single-input modes, direction comes from the phase inputs alone.
// - In hardware-direction mode, phase A low counts down and high counts up.
// - In software-direction mode, direction follows the direction command word.
// - In 32-bit modes the count is signed over the full 32-bit range.
// - In 16-bit modes the count is 0 up to the ring length less one.
// - Each compare output sets when the count equals its compare value and stays set.
// - A compare output clears only by its reset command, never by a mismatch.
// - The hardware compare output is set directly by the compare logic.
// - The software compare output follows a match within 300 microseconds.
// - In 32-bit modes counting wraps between maximum and minimum.
// - In 16-bit modes counting wraps between zero and ring length less one.
// - In add/subtract mode simultaneous up and down pulses leave the count alone.
// - Direction word zero counts up and one counts down.
`timescale 1ns/10ps
`default_nettype none
module quadrature_pulse_counter_compare #(
   parameter int SCAN_DIV = pulse_count_pkg::SW_SCAN_DIV
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic phase_a,
   input wire logic phase_b,
   input wire logic [4:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   output logic hardware_compare_output,
   output logic software_compare_output,
   output logic irq
);
   // Refuse a scan period that would break the latency bound
   if (SCAN_DIV < 1 || SCAN_DIV + 4 > pulse_count_pkg::SW_LATENCY_CYC) begin : g_bad_div
      $error("SCAN_DIV out of range");
   end

   logic [1:0] lvl;
   logic [1:0] rise;
   logic [1:0] fall;
   phase_edge_detect u_edges (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .phase_raw({phase_b, phase_a}),
      .phase_level(lvl),
      .phase_rise(rise),
      .phase_fall(fall)
   );

   // Decode the mode word into input style and width
   function automatic pulse_count_pkg::input_style_e style_of(input logic [3:0] m);
      case (m[3:1])
         3'h0: style_of = pulse_count_pkg::STYLE_EDGE1;
         3'h1: style_of = pulse_count_pkg::STYLE_EDGE2;
         3'h2: style_of = pulse_count_pkg::STYLE_EDGE4;
         3'h3: style_of = pulse_count_pkg::STYLE_ADDSUB;
         3'h4: style_of = pulse_count_pkg::STYLE_HWDIR;
         default: style_of = pulse_count_pkg::STYLE_SWDIR;
      endcase
   endfunction : style_of

   logic [3:0] mode_reg, mode_next;
   logic dir_reg, dir_next;
   logic [16:0] ring_reg, ring_next;
   logic [31:0] hw_cmp_reg, hw_cmp_next;
   logic [31:0] sw_cmp_reg, sw_cmp_next;
   logic [31:0] count_reg, count_next;
   logic hw_out_reg, hw_out_next;
   logic sw_out_reg, sw_out_next;
   logic [2:0] irq_stat_reg, irq_stat_next;
   logic [2:0] irq_mask_reg, irq_mask_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [15:0] scan_reg, scan_next;
   logic sw_hit_reg, sw_hit_next;
   pulse_count_pkg::count_step_s step;
   pulse_count_pkg::input_style_e style;
   logic wide;
   logic [31:0] top16;
   logic wrapped;
   logic hw_match;
   logic scan_tick;
   logic clr_hw;
   logic clr_sw;
   logic [2:0] events;

   assign style = style_of(mode_reg);
   assign wide = ~mode_reg[0]; // Even modes count 32 bits
   assign top16 = {15'h0000, ring_reg - 17'h0_0001};
   assign clr_hw = reg_write && reg_addr == pulse_count_pkg::OFS_COMMAND && reg_wdata[pulse_count_pkg::CMD_CLR_HW];
   assign clr_sw = reg_write && reg_addr == pulse_count_pkg::OFS_COMMAND && reg_wdata[pulse_count_pkg::CMD_CLR_SW];

   // Count step per input style
   always_comb begin
      step = '0;
      case (style)
         pulse_count_pkg::STYLE_EDGE1: begin
            step.up = rise[0] & ~lvl[1];
            step.down = fall[0] & ~lvl[1];
         end
         pulse_count_pkg::STYLE_EDGE2: begin
            step.up = (rise[0] & ~lvl[1]) | (fall[0] & lvl[1]);
            step.down = (rise[0] & lvl[1]) | (fall[0] & ~lvl[1]);
         end
         pulse_count_pkg::STYLE_EDGE4: begin
            step.up = (rise[0] & ~lvl[1]) | (fall[0] & lvl[1]) | (rise[1] & lvl[0]) | (fall[1] & ~lvl[0]);
            step.down = (rise[0] & lvl[1]) | (fall[0] & ~lvl[1]) | (rise[1] & ~lvl[0]) | (fall[1] & lvl[0]);
         end
         pulse_count_pkg::STYLE_ADDSUB: begin
            step.up = rise[0] & ~rise[1];
            step.down = rise[1] & ~rise[0];
         end
         pulse_count_pkg::STYLE_HWDIR: begin
            step.up = rise[1] & lvl[0];
            step.down = rise[1] & ~lvl[0];
         end
         pulse_count_pkg::STYLE_SWDIR: begin
            step.up = rise[1] & ~dir_reg;
            step.down = rise[1] & dir_reg;
         end
         default: step = '0;
      endcase
   end

   // Next count with wrap handling
   always_comb begin
      count_next = count_reg;
      wrapped = 1'b0;
      if (step.up) begin
         if (wide) begin
            count_next = count_reg + 32'h0000_0001;
            wrapped = count_reg == 32'h7FFF_FFFF;
         end else if (count_reg >= top16) begin
            count_next = 32'h0000_0000;
            wrapped = 1'b1;
         end else begin
            count_next = count_reg + 32'h0000_0001;
         end
      end else if (step.down) begin
         if (wide) begin
            count_next = count_reg - 32'h0000_0001;
            wrapped = count_reg == 32'h8000_0000;
         end else if (count_reg == 32'h0000_0000) begin
            count_next = top16;
            wrapped = 1'b1;
         end else begin
            count_next = count_reg - 32'h0000_0001;
         end
      end
      if (reg_write && reg_addr == pulse_count_pkg::OFS_COUNT) begin
         count_next = wide ? reg_wdata : {16'h0000, reg_wdata[15:0]};
      end
      if (reg_write && reg_addr == pulse_count_pkg::OFS_MODE) begin
         count_next = 32'h0000_0000;
      end
   end

   // Compare outputs: set wins over clear
   assign hw_match = count_reg == hw_cmp_reg;
   assign scan_tick = scan_reg == 16'(SCAN_DIV - 1);
   always_comb begin
      hw_out_next = hw_out_reg;
      if (clr_hw) hw_out_next = 1'b0;
      if (hw_match) hw_out_next = 1'b1;
      scan_next = scan_tick ? 16'h0000 : scan_reg + 16'h0001;
      sw_hit_next = sw_hit_reg | (count_reg == sw_cmp_reg); // Catch matches between scans
      if (scan_tick) sw_hit_next = count_reg == sw_cmp_reg;
      sw_out_next = sw_out_reg;
      if (clr_sw) sw_out_next = 1'b0;
      if (scan_tick && sw_hit_reg) sw_out_next = 1'b1;
   end

   // Sticky interrupt status, write one to clear, events win
   assign events = {wrapped, scan_tick & sw_hit_reg & ~sw_out_reg, hw_match & ~hw_out_reg};
   always_comb begin
      irq_stat_next = irq_stat_reg;
      if (reg_write && reg_addr == pulse_count_pkg::OFS_IRQ_STATUS) irq_stat_next = irq_stat_reg & ~reg_wdata[2:0];
      irq_stat_next = irq_stat_next | events;
   end

   // Configuration writes; a mode write restores the direction, ring and compare defaults
   always_comb begin
      mode_next = mode_reg;
      dir_next = dir_reg;
      ring_next = ring_reg;
      hw_cmp_next = hw_cmp_reg;
      sw_cmp_next = sw_cmp_reg;
      irq_mask_next = irq_mask_reg;
      if (reg_write) begin
         case (reg_addr)
            pulse_count_pkg::OFS_MODE: begin
               if (reg_wdata <= 32'h0000_000B) mode_next = reg_wdata[3:0]; // Whole word checked, high bits refuse too
               dir_next = 1'b0;
               ring_next = pulse_count_pkg::RING_RESET;
               hw_cmp_next = pulse_count_pkg::CMP_RESET;
               sw_cmp_next = pulse_count_pkg::CMP_RESET;
            end
            pulse_count_pkg::OFS_DIR: dir_next = reg_wdata[0];
            pulse_count_pkg::OFS_RING: begin
               if (reg_wdata >= 32'(pulse_count_pkg::RING_MIN) && reg_wdata <= 32'(pulse_count_pkg::RING_RESET))
                  ring_next = reg_wdata[16:0];
            end
            pulse_count_pkg::OFS_HW_CMP: hw_cmp_next = reg_wdata;
            pulse_count_pkg::OFS_SW_CMP: sw_cmp_next = reg_wdata;
            pulse_count_pkg::OFS_IRQ_MASK: irq_mask_next = reg_wdata[2:0];
            default: mode_next = mode_reg;
         endcase
      end
   end

   // Read mux, registered one cycle after the strobe
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (reg_read) begin
         case (reg_addr)
            pulse_count_pkg::OFS_MODE: rdata_next = {28'h000_0000, mode_reg};
            pulse_count_pkg::OFS_DIR: rdata_next = {31'h0000_0000, dir_reg};
            pulse_count_pkg::OFS_RING: rdata_next = {15'h0000, ring_reg};
            pulse_count_pkg::OFS_HW_CMP: rdata_next = hw_cmp_reg;
            pulse_count_pkg::OFS_SW_CMP: rdata_next = sw_cmp_reg;
            pulse_count_pkg::OFS_COUNT: rdata_next = count_reg;
            pulse_count_pkg::OFS_RESULTS: rdata_next = {30'h0000_0000, sw_out_reg, hw_out_reg};
            pulse_count_pkg::OFS_PINS: rdata_next = {30'h0000_0000, lvl};
            pulse_count_pkg::OFS_IRQ_STATUS: rdata_next = {29'h0000_0000, irq_stat_reg};
            pulse_count_pkg::OFS_IRQ_MASK: rdata_next = {29'h0000_0000, irq_mask_reg};
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   // State registers
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         mode_reg <= pulse_count_pkg::MODE_RESET;
         dir_reg <= 1'b0;
         ring_reg <= pulse_count_pkg::RING_RESET;
         hw_cmp_reg <= pulse_count_pkg::CMP_RESET;
         sw_cmp_reg <= pulse_count_pkg::CMP_RESET;
         count_reg <= 32'h0000_0000;
         hw_out_reg <= 1'b0;
         sw_out_reg <= 1'b0;
         irq_stat_reg <= 3'h0;
         irq_mask_reg <= 3'h0;
         rdata_reg <= 32'h0000_0000;
         scan_reg <= 16'h0000;
         sw_hit_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next;
         dir_reg <= dir_next;
         ring_reg <= ring_next;
         hw_cmp_reg <= hw_cmp_next;
         sw_cmp_reg <= sw_cmp_next;
         count_reg <= count_next;
         hw_out_reg <= hw_out_next;
         sw_out_reg <= sw_out_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         rdata_reg <= rdata_next;
         scan_reg <= scan_next;
         sw_hit_reg <= sw_hit_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign hardware_compare_output = hw_out_reg;
   assign software_compare_output = sw_out_reg;
   assign irq = |(irq_stat_reg & irq_mask_reg);

   // Checks
   property p_hw_set;
      @(posedge sys_clk) disable iff (!reset_n) hw_match |=> hardware_compare_output;
   endproperty
   a_hw_set: assert property (p_hw_set) else $error("hw compare not set on match");
   property p_hw_hold;
      @(posedge sys_clk) disable iff (!reset_n) hardware_compare_output && !clr_hw |=> hardware_compare_output;
   endproperty
   a_hw_hold: assert property (p_hw_hold) else $error("hw compare dropped without command");
   property p_sw_hold;
      @(posedge sys_clk) disable iff (!reset_n) software_compare_output && !clr_sw |=> software_compare_output;
   endproperty
   a_sw_hold: assert property (p_sw_hold) else $error("sw compare dropped without command");
   sequence s_sw_match;
      count_reg == sw_cmp_reg && !clr_sw;
   endsequence
   property p_sw_latency;
      @(posedge sys_clk) disable iff (!reset_n) s_sw_match ##1 !clr_sw [*1] |-> ##[0:600] software_compare_output;
   endproperty
   a_sw_latency: assert property (p_sw_latency) else $error("sw compare too slow");
   property p_addsub_both;
      @(posedge sys_clk) disable iff (!reset_n)
         style == pulse_count_pkg::STYLE_ADDSUB && rise == 2'b11 && !reg_write |=> count_reg == $past(count_reg);
   endproperty
   a_addsub_both: assert property (p_addsub_both) else $error("count moved on double pulse");
   property p_wrap16;
      @(posedge sys_clk) disable iff (!reset_n)
         !wide && step.up && count_reg == top16 && !reg_write |=> count_reg == 32'h0000_0000;
   endproperty
   a_wrap16: assert property (p_wrap16) else $error("16-bit wrap up wrong");
   property p_range16;
      @(posedge sys_clk) disable iff (!reset_n) !wide && !$past(reg_write) |-> count_reg <= top16 || $past(count_reg) > top16;
   endproperty
   a_range16: assert property (p_range16) else $error("16-bit count above limit");
   property p_wrap32;
      @(posedge sys_clk) disable iff (!reset_n)
         wide && step.down && count_reg == 32'h8000_0000 && !reg_write |=> count_reg == 32'h7FFF_FFFF;
   endproperty
   a_wrap32: assert property (p_wrap32) else $error("32-bit wrap down wrong");
   property p_swdir;
      @(posedge sys_clk) disable iff (!reset_n)
         style == pulse_count_pkg::STYLE_SWDIR && wide && rise[1] && !reg_write |=>
            count_reg == ($past(dir_reg) ? $past(count_reg) - 32'h0000_0001 : $past(count_reg) + 32'h0000_0001);
   endproperty
   a_swdir: assert property (p_swdir) else $error("sw direction wrong");
endmodule : quadrature_pulse_counter_compare
`default_nettype wire

/* bench/encoder_model.sv */
// Purpose: Behavioural pulse source that drives the two phase pins
// Assumes: Each pin level is held long enough to pass the two-flop synchroniser
// Notes: Levels change just after a rising edge; callers start right after an edge
`timescale 1ns/10ps
`default_nettype none
module encoder_model #(
   parameter int HOLD = 8
) (
   input wire logic sys_clk,
   output logic phase_a,
   output logic phase_b
);
   // Both pins rest low until a scenario asks for pulses
   initial begin
      phase_a = 1'b0;
      phase_b = 1'b0;
   end

   // Hold each level for several cycles so no edge is lost in synchronisation
   task automatic drive(input logic a, input logic b);
      phase_a <= a;
      phase_b <= b;
      repeat (HOLD) @(posedge sys_clk);
   endtask : drive

   // Pulse the masked pins k times; unmasked pins keep their level
   task automatic pulse(input logic ma, input logic mb, input int k);
      logic a0;
      logic b0;
      a0 = phase_a;
      b0 = phase_b;
      repeat (k) begin
         drive(a0 | ma, b0 | mb);
         drive(a0 & ~ma, b0 & ~mb);
      end
   endtask : pulse

   // Full quadrature cycles; A leads B when turning forward
   task automatic quad(input logic up, input int k);
      repeat (k) begin
         if (up) begin
            drive(1'b1, 1'b0);
            drive(1'b1, 1'b1);
            drive(1'b0, 1'b1);
         end else begin
            drive(1'b0, 1'b1);
            drive(1'b1, 1'b1);
            drive(1'b1, 1'b0);
         end
         drive(1'b0, 1'b0);
      end
   endtask : quad
endmodule : encoder_model
`default_nettype wire

/* bench/tb.sv */
// Purpose: Self-checking bench for the pulse counter and compare core
// Assumes: Register reads are scored from a queue by a separate watcher
// Notes: Scan divider is shortened so the software compare settles quickly
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam int SCAN = 4;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   wire logic phase_a;
   wire logic phase_b;
   logic [4:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_write;
   logic reg_read;
   logic [31:0] reg_rdata;
   logic hardware_compare_output;
   logic software_compare_output;
   logic irq;
   int err_count = 0;
   int compares = 0;
   int n;
   int seed;
   logic [31:0] exp_q[$];
   logic rd_seen = 1'b0;

   // 50 MHz clock
   always #10 sys_clk = ~sys_clk;

   quadrature_pulse_counter_compare #(.SCAN_DIV(SCAN)) dut (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .phase_a(phase_a),
      .phase_b(phase_b),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_write(reg_write),
      .reg_read(reg_read),
      .reg_rdata(reg_rdata),
      .hardware_compare_output(hardware_compare_output),
      .software_compare_output(software_compare_output),
      .irq(irq)
   );

   encoder_model enc (
      .sys_clk(sys_clk),
      .phase_a(phase_a),
      .phase_b(phase_b)
   );

   // Verdict and end of run
   task automatic results;
      if (err_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results

   task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: read data %h, wanted %h", $time, got, exp);
      end
   endtask : chk_rd

   task automatic chk_out(input logic got, input logic exp, input string what);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s is %b, wanted %b", $time, what, got, exp);
      end
   endtask : chk_out

   // Read data stands only in the cycle after the strobe, so sample mid-cycle
   always @(posedge sys_clk) begin
      rd_seen <= reg_read;
   end
   always @(negedge sys_clk) begin
      if (rd_seen === 1'b1) begin
         if (exp_q.size() == 0) begin
            err_count++;
            $display("unexpected at %0t: read data with no note", $time);
         end else begin
            chk_rd(reg_rdata, exp_q.pop_front());
         end
      end else if (reset_n === 1'b1) begin
         chk_rd(reg_rdata, 32'h0000_0000); // Idle read data must be zero
      end
   end

   // A spare edge after each strobe keeps one assignment per time step
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
      @(posedge sys_clk);
   endtask : wr

   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      exp_q.push_back(exp);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      @(posedge sys_clk);
   endtask : rd

   // Watchdog sized well above the expected run
   initial begin
      repeat (30000) @(posedge sys_clk);
      err_count++;
      results();
   end

   // Main sequence
   initial begin
      reg_addr = 5'h00;
      reg_wdata = 32'h0000_0000;
      reg_write = 1'b0;
      reg_read = 1'b0;
      seed = $urandom(21883);
      repeat (6) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      chk_out(hardware_compare_output, 1'b0, "hw compare");
      chk_out(software_compare_output, 1'b0, "sw compare");
      chk_out(irq, 1'b0, "irq");
      rd(pulse_count_pkg::OFS_MODE, 32'h0000_0000);
      rd(pulse_count_pkg::OFS_RING, 32'h0001_0000);
      rd(pulse_count_pkg::OFS_HW_CMP, 32'h0000_7FFF);
      rd(pulse_count_pkg::OFS_COUNT, 32'h0000_0000);
      rd(5'h03, 32'h0000_0000);
      // A mode above eleven is refused even when its low bits look legal
      wr(pulse_count_pkg::OFS_MODE, 32'h0000_0003);
      wr(pulse_count_pkg::OFS_MODE, 32'h0000_0012);
      rd(pulse_count_pkg::OFS_MODE, 32'h0000_0003);
      // Every quadrature mode: one cycle forward then one back
      for (int m = 0; m < 6; m++) begin
         wr(pulse_count_pkg::OFS_MODE, 32'(m));
         enc.quad(1'b1, 1);
         rd(pulse_count_pkg::OFS_COUNT, 32'h0000_0001 << (m / 2));
         enc.quad(1'b0, 1);
         rd(pulse_count_pkg::OFS_COUNT, 32'h0000_0000);
      end
      // Signed 32-bit wrap both ways, wrap event raises the interrupt
      wr(pulse_count_pkg::OFS_MODE, 32'h0000_0004);
      wr(pulse_count_pkg::OFS_IRQ_STATUS, 32'h0000_0007);
      wr(pulse_count_pkg::OFS_COUNT, 32'h7FFF_FFFE);
      enc.quad(1'b1, 1);
      rd(pulse_count_pkg::OFS_COUNT, 32'h8000_0002);
      enc.quad(1'b0, 1);
      rd(pulse_count_pkg::OFS_COUNT, 32'h7FFF_FFFE);
      rd(pulse_count_pkg::OFS_IRQ_STATUS, 32'h0000_0004);
      chk_out(irq, 1'b0, "irq masked");
      wr(pulse_count_pkg::OFS_IRQ_MASK, 32'h0000_0004);
      chk_out(irq, 1'b1, "irq unmasked");
      wr(pulse_count_pkg::OFS_IRQ_STATUS, 32'h0000_0004);
      chk_out(irq, 1'b0, "irq cleared");
      // 16-bit ring of five; a ring of one is refused
      wr(pulse_count_pkg::OFS_MODE, 32'h0000_0005);
      wr(pulse_count_pkg::OFS_RING, 32'h0000_0005);
      wr(pulse_count_pkg::OFS_RING, 32'h0000_0001);
      rd(pulse_count_pkg::OFS_RING, 32'h0000_0005);
      enc.quad(1'b0, 1);
      rd(pulse_count_pkg::OFS_COUNT, 32'h0000_0001);
      enc.quad(1'b1, 1);
      rd(pulse_count_pkg::OFS_COUNT, 32'h0000_0000);
      // Add/subtract inputs, simultaneous pulses cancel
      wr(pulse_count_pkg::OFS_MODE, 32'h0000_0006);
      enc.pulse(1'b1, 1'b0, 3);
      enc.pulse(1'b0, 1'b1, 1);
      enc.pulse(1'b1, 1'b1, 2);
      rd(pulse_count_pkg::OFS_COUNT, 32'h0000_0002);
      // Direction from the level of phase A
      wr(pulse_count_pkg::OFS_MODE, 32'h0000_0008);
      enc.drive(1'b1, 1'b0);
      rd(pulse_count_pkg::OFS_PINS, 32'h0000_0001);
      enc.pulse(1'b0, 1'b1, 2);
      enc.drive(1'b0, 1'b0);
      enc.pulse(1'b0, 1'b1, 3);
      rd(pulse_count_pkg::OFS_COUNT, 32'hFFFF_FFFF);
      // Software direction with both compares at a random target
      wr(pulse_count_pkg::OFS_MODE, 32'h0000_000A);
      wr(pulse_count_pkg::OFS_IRQ_STATUS, 32'h0000_0007);
      n = 2 + ($urandom % 5);
      wr(pulse_count_pkg::OFS_HW_CMP, 32'(n));
      wr(pulse_count_pkg::OFS_SW_CMP, 32'(n));
      rd(pulse_count_pkg::OFS_SW_CMP, 32'(n));
      enc.pulse(1'b0, 1'b1, n - 1);
      chk_out(hardware_compare_output, 1'b0, "hw before match");
      enc.pulse(1'b0, 1'b1, 1);
      chk_out(hardware_compare_output, 1'b1, "hw on match");
      chk_out(software_compare_output, 1'b1, "sw on match");
      enc.pulse(1'b0, 1'b1, 1);
      chk_out(hardware_compare_output, 1'b1, "hw after mismatch");
      chk_out(software_compare_output, 1'b1, "sw after mismatch");
      rd(pulse_count_pkg::OFS_RESULTS, 32'h0000_0003);
      rd(pulse_count_pkg::OFS_IRQ_STATUS, 32'h0000_0003);
      wr(pulse_count_pkg::OFS_IRQ_MASK, 32'h0000_0003);
      rd(pulse_count_pkg::OFS_IRQ_MASK, 32'h0000_0003);
      chk_out(irq, 1'b1, "irq compare");
      wr(pulse_count_pkg::OFS_COMMAND, 32'h0000_0001);
      chk_out(hardware_compare_output, 1'b0, "hw cleared");
      chk_out(software_compare_output, 1'b1, "sw kept");
      wr(pulse_count_pkg::OFS_COMMAND, 32'h0000_0002);
      chk_out(software_compare_output, 1'b0, "sw cleared");
      wr(pulse_count_pkg::OFS_DIR, 32'h0000_0001);
      rd(pulse_count_pkg::OFS_DIR, 32'h0000_0001);
      enc.pulse(1'b0, 1'b1, 3);
      rd(pulse_count_pkg::OFS_COUNT, 32'(n - 2));
      wr(pulse_count_pkg::OFS_IRQ_STATUS, 32'h0000_0007);
      chk_out(irq, 1'b0, "irq all cleared");
      results();
   end
endmodule : tb
`default_nettype wire
